// ### hdl/dfh_host.sv
// module: host controller driving a two-die parallel flash through its pins
`timescale 1ns/1ps
module dfh_host
  import dfh_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  input  wire logic                CLK_EN,
  input  wire logic                REQ_VALID,
  output logic                     REQ_READY,
  input  wire dfh_req_s            REQ,
  output logic                     RSP_VALID,
  output dfh_rsp_s                 RSP,
  output logic                     DIE_BUSY_0,
  output logic                     DIE_BUSY_1,
  output dfh_bus_s                 FL_BUS,
  input  wire logic [DATA_W-1:0]   FL_DQ_I,
  output logic [DATA_W-1:0]        FL_DQ_O,
  output logic                     FL_DQ_OE,
  input  wire logic                FL_RDY_I
);

  // ************************************************************
  // states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WAIT  = 3'h1,
    ST_SETUP = 3'h3,
    ST_STROB = 3'h7,
    ST_HOLD  = 3'h5,
    ST_RST   = 3'h4,
    ST_RECOV = 3'h6
  } dfh_st_e;

  dfh_st_e              st_ff, nxt_st;
  dfh_req_s             req_ff, nxt_req;
  logic [2:0]           step_ff, nxt_step;
  logic [CNT_W-1:0]     cnt_ff, nxt_cnt;
  logic [ADDR_W-1:0]    addr_ff, nxt_addr;
  logic [DATA_W-1:0]    dout_ff, nxt_dout;
  logic                 rd_ff, nxt_rd;
  logic [DATA_W-1:0]    rdat_ff, nxt_rdat;
  logic                 rsp_ff, nxt_rsp;
  logic                 erase_ff, nxt_erase;
  logic                 edie_ff, nxt_edie;
  logic [DATA_W-1:0]    dq_s1_ff, dq_s2_ff;
  logic                 rdy_s1_ff, rdy_s2_ff;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dq_s1_ff  <= '0;
      dq_s2_ff  <= '0;
      rdy_s1_ff <= 1'b1;
      rdy_s2_ff <= 1'b1;
    end else if (CLK_EN) begin
      dq_s1_ff  <= FL_DQ_I;
      dq_s2_ff  <= dq_s1_ff;
      rdy_s1_ff <= FL_RDY_I;
      rdy_s2_ff <= rdy_s1_ff;
    end
  end

  // ************************************************************
  // address and sequence decode
  // ************************************************************
  wire                  die_sel   = req_ff.addr[DIE_BIT];
  wire [ADDR_W-1:0]     die_base  = die_sel ? DIE1_BASE : '0;
  wire [ADDR_W-1:0]     sect_base = {req_ff.addr[ADDR_W-1:SECT_LSB], 16'h0000};
  wire [ADDR_W-1:0]     id_addr   = sect_base | {19'h0, req_ff.addr[7:0]};
  wire                  is_erase  = (req_ff.op == DFH_OP_ERASE);
  wire                  is_id     = (req_ff.op == DFH_OP_IDRD);
  wire                  is_read   = (req_ff.op == DFH_OP_READ);
  wire [2:0]            last_step = is_erase ? 3'h5 : (is_id ? 3'h4 : 3'h0);
  wire                  die_busy  = erase_ff && !rdy_s2_ff && (edie_ff == req_ff.addr[DIE_BIT]);
  wire                  cmd_op    = !is_read && req_ff.op != DFH_OP_RESET;
  wire                  blocked   = cmd_op && die_busy;

  // erase: 555/AA 2AA/55 555/80 555/AA 2AA/55 sector/30; id: unlock, 555/90, read, F0
  logic [ADDR_W-1:0]    seq_addr;
  logic [DATA_W-1:0]    seq_data;
  logic                 seq_rd;
  always_comb begin
    seq_rd   = 1'b0;
    seq_addr = die_base | UNLOCK1_ADDR;
    seq_data = UNLOCK1_DATA;
    unique case (step_ff)
      3'h0: begin
        if (is_read) begin
          seq_addr = req_ff.addr;
          seq_rd   = 1'b1;
        end else if (req_ff.op == DFH_OP_WRITE) begin
          seq_addr = req_ff.addr;
          seq_data = req_ff.data;
        end
      end
      3'h1, 3'h4: begin
        seq_addr = die_base | UNLOCK2_ADDR;
        seq_data = UNLOCK2_DATA;
        if (is_id && step_ff == 3'h4) begin
          seq_addr = die_base | UNLOCK1_ADDR;
          seq_data = RESET_CMD;
        end
      end
      3'h2: begin
        seq_data = is_erase ? ERASE_SETUP : ID_ENTER;
        if (is_id) seq_addr = sect_base | UNLOCK1_ADDR;
      end
      3'h3: begin
        if (is_id) begin
          seq_addr = id_addr;
          seq_rd   = 1'b1;
        end
      end
      3'h5: begin
        seq_addr = sect_base;
        seq_data = SECT_ERASE;
      end
      default: begin
        seq_rd = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    nxt_st    = st_ff;
    nxt_req   = req_ff;
    nxt_step  = step_ff;
    nxt_cnt   = cnt_ff;
    nxt_addr  = addr_ff;
    nxt_dout  = dout_ff;
    nxt_rd    = rd_ff;
    nxt_rdat  = rdat_ff;
    nxt_rsp   = 1'b0;
    nxt_erase = erase_ff;
    nxt_edie  = edie_ff;
    if (erase_ff && rdy_s2_ff && st_ff != ST_SETUP && st_ff != ST_STROB) nxt_erase = 1'b0;
    unique case (st_ff)
      ST_IDLE: begin
        if (REQ_VALID) begin
          nxt_req  = REQ;
          nxt_step = 3'h0;
          nxt_st   = ST_WAIT;
          if (REQ.op == DFH_OP_RESET) begin
            nxt_st  = ST_RST;
            nxt_cnt = CNT_W'(CYC_RESET);
          end
        end
      end
      ST_WAIT: begin
        if (!blocked) begin
          nxt_addr = seq_addr;
          nxt_dout = seq_data;
          nxt_rd   = seq_rd;
          nxt_cnt  = CNT_W'(CYC_CYCLE);
          nxt_st   = ST_SETUP;
        end
      end
      ST_SETUP: begin
        nxt_st = ST_STROB;
      end
      ST_STROB: begin
        if (cnt_ff <= CNT_W'(1)) begin
          if (rd_ff) nxt_rdat = dq_s2_ff;
          nxt_cnt = CNT_W'(CYC_RECOV);
          nxt_st  = ST_HOLD;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      ST_HOLD: begin
        if (cnt_ff <= CNT_W'(1)) begin
          if (step_ff == last_step) begin
            nxt_rsp = 1'b1;
            nxt_st  = ST_IDLE;
            if (is_erase) begin
              nxt_erase = 1'b1;
              nxt_edie  = die_sel;
            end
          end else begin
            nxt_step = step_ff + 3'h1;
            nxt_st   = ST_WAIT;
          end
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      ST_RST: begin
        if (cnt_ff <= CNT_W'(1)) begin
          nxt_cnt   = CNT_W'(CYC_RECOV);
          nxt_erase = 1'b0;
          nxt_st    = ST_RECOV;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      ST_RECOV: begin
        if (cnt_ff <= CNT_W'(1)) begin
          nxt_rsp = 1'b1;
          nxt_st  = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_ff    <= ST_IDLE;
      req_ff   <= '0;
      step_ff  <= '0;
      cnt_ff   <= '0;
      addr_ff  <= '0;
      dout_ff  <= '0;
      rd_ff    <= 1'b0;
      rdat_ff  <= '0;
      rsp_ff   <= 1'b0;
      erase_ff <= 1'b0;
      edie_ff  <= 1'b0;
    end else if (CLK_EN) begin
      st_ff    <= nxt_st;
      req_ff   <= nxt_req;
      step_ff  <= nxt_step;
      cnt_ff   <= nxt_cnt;
      addr_ff  <= nxt_addr;
      dout_ff  <= nxt_dout;
      rd_ff    <= nxt_rd;
      rdat_ff  <= nxt_rdat;
      rsp_ff   <= nxt_rsp;
      erase_ff <= nxt_erase;
      edie_ff  <= nxt_edie;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  wire strobe = (st_ff == ST_STROB);
  wire busy_now = erase_ff && !rdy_s2_ff;

  assign REQ_READY      = (st_ff == ST_IDLE);
  assign RSP_VALID      = rsp_ff;
  assign RSP.data       = rdat_ff;
  assign RSP.prot       = (rdat_ff[7:0] == PROT_SET);
  assign RSP.fact_lock  = (rdat_ff[7:0] == IND_HI_LOCK) || (rdat_ff[7:0] == IND_LO_LOCK);
  assign RSP.hi_sect_wp = (rdat_ff[7:0] == IND_HI_OPEN) || (rdat_ff[7:0] == IND_HI_LOCK);
  assign DIE_BUSY_0     = busy_now && !edie_ff;
  assign DIE_BUSY_1     = busy_now && edie_ff;
  assign FL_BUS.ce_n    = !(st_ff == ST_SETUP || strobe);
  assign FL_BUS.oe_n    = !(strobe && rd_ff);
  assign FL_BUS.we_n    = !(strobe && !rd_ff);
  assign FL_BUS.reset_n = (st_ff != ST_RST);
  assign FL_BUS.addr    = addr_ff;
  assign FL_DQ_O        = dout_ff;
  assign FL_DQ_OE       = (st_ff == ST_SETUP || strobe) && !rd_ff;

endmodule

// ### hdl/dfh_pkg.sv
// package: constants and types for the dual-die flash host controller
// Summary of operation
// - host adds die base offset zero or 0x4000000 to every command address except the ID entry 555/90 and the erase sector/30, which use the sector base
// - sector erase is six writes: 555/AA 2AA/55 555/80 555/AA 2AA/55 sector/30
// - unlock pairs carry die select bit of the intended die
// - address arguments carry the die select bit of their target die
// - response reads use the same die select as the producing command
package dfh_pkg;

  localparam int ADDR_W = 27;
  localparam int DATA_W = 16;
  localparam int SECT_W = 11;
  localparam int SECT_LSB = 16;
  localparam int DIE_BIT = 26;
  localparam logic [26:0] DIE1_BASE = 27'h4000000;
  localparam logic [26:0] UNLOCK1_ADDR = 27'h0000555;
  localparam logic [26:0] UNLOCK2_ADDR = 27'h00002AA;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] ERASE_SETUP = 16'h0080;
  localparam logic [15:0] SECT_ERASE = 16'h0030;
  localparam logic [15:0] RESET_CMD = 16'h00F0;
  localparam logic [15:0] ID_ENTER = 16'h0090;
  localparam logic [7:0] ID_MAKER = 8'h00;
  localparam logic [7:0] ID_DEV1 = 8'h01;
  localparam logic [7:0] ID_PROT = 8'h02;
  localparam logic [7:0] ID_IND = 8'h03;
  localparam logic [7:0] ID_DEV2 = 8'h0E;
  localparam logic [7:0] ID_DEV3 = 8'h0F;
  localparam logic [7:0] IND_HI_OPEN = 8'h3F;
  localparam logic [7:0] IND_HI_LOCK = 8'hBF;
  localparam logic [7:0] IND_LO_OPEN = 8'h2F;
  localparam logic [7:0] IND_LO_LOCK = 8'hAF;
  localparam logic [7:0] PROT_SET = 8'h01;
  localparam logic [7:0] PROT_CLR = 8'h00;

  localparam int CLK_MHZ = 40;
  localparam int T_CYCLE_NS = 120;
  localparam int T_RESET_NS = 500;
  localparam int T_RECOV_NS = 50;
  localparam int CYC_CYCLE = (T_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_RESET = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_RECOV = (T_RECOV_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    DFH_OP_READ  = 3'h0,
    DFH_OP_WRITE = 3'h1,
    DFH_OP_ERASE = 3'h2,
    DFH_OP_IDRD  = 3'h3,
    DFH_OP_RESET = 3'h4
  } dfh_op_e;

  typedef struct packed {
    dfh_op_e             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } dfh_req_s;

  typedef struct packed {
    logic [DATA_W-1:0]   data;
    logic                prot;
    logic                fact_lock;
    logic                hi_sect_wp;
  } dfh_rsp_s;

  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic                reset_n;
    logic [ADDR_W-1:0]   addr;
  } dfh_bus_s;

endpackage

// ### testbench/dfh_flash_model.sv
// partner: behavioural two-die flash answering the host pins
`timescale 1ns/1ps
module dfh_flash_model
  import dfh_pkg::*;
#(
  parameter logic [15:0] MAKER    = 16'h0A5C, // arbitrary code
  parameter logic [15:0] DEV_W1   = 16'h1A01, // arbitrary code
  parameter logic [15:0] DEV_W2   = 16'h1A0E, // arbitrary code
  parameter logic [15:0] DEV_W3   = 16'h1A0F, // arbitrary code
  parameter logic        LO_WP    = 1'b0,
  parameter int          BUSY_CYC = 120
)
(
  input  wire logic              CLK,
  input  wire dfh_bus_s          FL_BUS,
  input  wire logic [DATA_W-1:0] FL_DQ_O,
  output logic [DATA_W-1:0]      FL_DQ_I,
  output logic                   FL_RDY_I,
  output logic [ADDR_W-1:0]      ERASED
);
  localparam logic [99:0] PRE = 100'h555AA2AA5555580555AA2AA55;
  logic [99:0] hist [2] = '{default: '0};
  logic [7:0]  busy [2] = '{default: '0};
  logic [10:0] isec [2] = '{default: '0};
  logic [1:0]  idm      = 2'b00;
  logic        we_q     = 1'b1;
  logic [15:0] last     = 16'h0000;
  logic        d;
  logic [19:0] w;
  initial ERASED = '0;
  function automatic logic [15:0] id_rd(input logic dd, input logic [7:0] o);
    case (o)
      8'h00: return MAKER;
      8'h01: return DEV_W1;
      8'h0E: return DEV_W2;
      8'h0F: return DEV_W3;
      8'h02: return {15'h0000, isec[dd][0]};
      8'h03: return LO_WP ? 16'hFF2F : 16'hFF3F;
      default: return 16'hFFFF;
    endcase
  endfunction
  // released bus shows the inverse of the last word
  always_comb begin
    if (!FL_BUS.ce_n && !FL_BUS.oe_n) begin
      if (idm[FL_BUS.addr[DIE_BIT]]) FL_DQ_I = id_rd(FL_BUS.addr[DIE_BIT], FL_BUS.addr[7:0]);
      else FL_DQ_I = FL_BUS.addr[15:0] ^ {5'h00, FL_BUS.addr[26:16]};
    end else FL_DQ_I = ~last;
  end
  assign FL_RDY_I = busy[0] == 8'h00 && busy[1] == 8'h00;
  always @(posedge CLK) begin
    we_q <= FL_BUS.we_n;
    if (!FL_BUS.oe_n) last <= FL_DQ_I;
    for (int i = 0; i < 2; i++) if (busy[i] != 8'h00) busy[i] <= busy[i] - 8'h01;
    if (!FL_BUS.reset_n) begin
      busy <= '{default: '0};
      hist <= '{default: '0};
      idm <= 2'b00;
    end else if (!FL_BUS.we_n && !FL_BUS.ce_n && we_q) begin
      d = FL_BUS.addr[DIE_BIT];
      w = {FL_BUS.addr[11:0], FL_DQ_O[7:0]};
      hist[d] <= {hist[d][79:0], w};
      if (w[7:0] == 8'h30 && hist[d] == PRE) begin
        busy[d] <= 8'(BUSY_CYC);
        ERASED <= FL_BUS.addr;
      end
      if (w == 20'h55590 && hist[d][39:0] == PRE[39:0]) begin
        idm[d] <= 1'b1;
        isec[d] <= FL_BUS.addr[26:16];
      end
      if (w[7:0] == 8'hF0) idm[d] <= 1'b0;
    end
  end
endmodule

// ### testbench/dfh_host_bench.sv
// testbench: host against the flash model, queued result checks
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module dfh_host_bench
  import dfh_pkg::*;
;
  logic              CLK = 1'b0;
  logic              SYS_RST = 1'b1;
  logic              REQ_VALID = 1'b0;
  dfh_req_s          REQ = '0;
  logic              REQ_READY, RSP_VALID, DIE_BUSY_0, DIE_BUSY_1, FL_DQ_OE, FL_RDY_I;
  dfh_rsp_s          RSP;
  dfh_bus_s          FL_BUS;
  logic [DATA_W-1:0] FL_DQ_I, FL_DQ_O;
  logic [ADDR_W-1:0] erased, a;
  logic [16:0]       exp_q[$];
  logic [16:0]       e;
  int                n_fail = 0, check_count = 0, cyc = 0, seed = 12021;
  logic [26:0]       ra[6] = '{27'h0000000, 27'h000FFFF, 27'h0010000, 27'h3FFFFFF, 27'h4000000, 27'h7FFFFFF};
  logic [7:0]        io[6] = '{8'h00, 8'h01, 8'h0E, 8'h0F, 8'h03, 8'h02};
  logic [15:0]       iv[6] = '{16'h0A5C, 16'h1A01, 16'h1A0E, 16'h1A0F, 16'hFF3F, 16'h0000};
  always #12.5 CLK = ~CLK;
  dfh_host uut (.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(1'b1), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP), .DIE_BUSY_0(DIE_BUSY_0), .DIE_BUSY_1(DIE_BUSY_1),
    .FL_BUS(FL_BUS), .FL_DQ_I(FL_DQ_I), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE), .FL_RDY_I(FL_RDY_I));
  dfh_flash_model peer (.CLK(CLK), .FL_BUS(FL_BUS), .FL_DQ_O(FL_DQ_O), .FL_DQ_I(FL_DQ_I),
    .FL_RDY_I(FL_RDY_I), .ERASED(erased));
  function automatic logic [15:0] arr(input logic [26:0] x);
    return x[15:0] ^ {5'h00, x[26:16]};
  endfunction
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic do_op(input dfh_op_e opc, input logic [26:0] x, input logic [16:0] ex);
    int n;
    exp_q.push_back(ex);
    REQ_VALID <= 1'b1;
    REQ <= '{op: opc, addr: x, data: 16'($random(seed))};
    @(posedge CLK);
    while (REQ_READY !== 1'b1) @(posedge CLK);
    REQ_VALID <= 1'b0;
    n = 0;
    do @(posedge CLK); while (RSP_VALID !== 1'b1 && ++n < 400);
    `CHK("rsp_arrived", 1'b1, RSP_VALID)
  endtask
  // result watcher
  always @(negedge CLK) begin
    if (RSP_VALID === 1'b1) begin
      e = exp_q.pop_front();
      if (e[16]) `CHK("rsp_data", e[15:0], RSP.data)
    end
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'b0;
    foreach (ra[i]) do_op(DFH_OP_READ, ra[i], {1'b1, arr(ra[i])});
    repeat (6) begin
      a = 27'($random(seed));
      do_op(DFH_OP_READ, a, {1'b1, arr(a)});
    end
    for (int d = 0; d < 2; d++) begin
      foreach (io[i]) begin
        a = {d[0], d[0] ? 10'h3FF : 10'h002, 8'h00, io[i]};
        do_op(DFH_OP_IDRD, a, {1'b1, iv[i] | 16'(i == 5 && d == 1)});
        if (i == 4) `CHK("wp_high_flag", 1'b1, RSP.hi_sect_wp)
        if (i == 4) `CHK("lock_flag", 1'b0, RSP.fact_lock)
        if (i == 5) `CHK("prot_flag", d[0], RSP.prot)
      end
    end
    do_op(DFH_OP_ERASE, 27'h4010123, 17'h00000);
    repeat (4) @(posedge CLK);
    `CHK("erased_addr", 27'h4010000, erased)
    `CHK("busy_die1", 1'b1, DIE_BUSY_1)
    `CHK("busy_die0", 1'b0, DIE_BUSY_0)
    do_op(DFH_OP_READ, 27'h4010005, {1'b1, arr(27'h4010005)});
    do_op(DFH_OP_IDRD, 27'h0000000, {1'b1, 16'h0A5C});
    `CHK("busy_die1_held", 1'b1, DIE_BUSY_1)
    do_op(DFH_OP_IDRD, 27'h4010001, {1'b1, 16'h1A01});
    `CHK("busy_die1_done", 1'b0, DIE_BUSY_1)
    do_op(DFH_OP_ERASE, 27'h0000000, 17'h00000);
    `CHK("busy_die0_set", 1'b1, DIE_BUSY_0)
    do_op(DFH_OP_RESET, 27'h0000000, 17'h00000);
    repeat (4) @(posedge CLK);
    `CHK("busy_die0_abort", 1'b0, DIE_BUSY_0)
    do_op(DFH_OP_READ, 27'h0000123, {1'b1, arr(27'h0000123)});
    // cut a read in mid strobe with a system reset
    REQ_VALID <= 1'b1;
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b1;
    @(posedge CLK);
    `CHK("cycle_cut", 1'b0, FL_BUS.ce_n)
    SYS_RST <= 1'b0;
    @(posedge CLK);
    `CHK("idle_after_cut", 1'b1, REQ_READY && FL_BUS.ce_n && !FL_DQ_OE)
    do_op(DFH_OP_READ, 27'h7FF0000, {1'b1, arr(27'h7FF0000)});
    tally_and_finish();
  end
endmodule
bind dfh_host dfh_host_checker chk (.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID), .FL_BUS(FL_BUS), .FL_DQ_OE(FL_DQ_OE));

// ### testbench/dfh_host_checker.sv
// checker: bus timing and die addressing of the flash host
`timescale 1ns/1ps
module dfh_host_checker
  import dfh_pkg::*;
(
  input wire logic     CLK,
  input wire logic     SYS_RST,
  input wire logic     CLK_EN,
  input wire logic     REQ_VALID,
  input wire logic     REQ_READY,
  input wire dfh_req_s REQ,
  input wire logic     RSP_VALID,
  input wire dfh_bus_s FL_BUS,
  input wire logic     FL_DQ_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic              take;
  logic              rd_ff;
  logic [ADDR_W-1:0] adr_ff;
  assign take = CLK_EN && REQ_VALID && REQ_READY;
  always_ff @(posedge CLK) begin
    if (take) begin
      rd_ff <= REQ.op == DFH_OP_READ;
      adr_ff <= REQ.addr;
    end
  end
  a_reset_idle: assert property (disable iff (1'b0) SYS_RST |=> REQ_READY && FL_BUS.ce_n && FL_BUS.reset_n)
    else $error("host not idle after reset");
  a_rsp_single: assert property (RSP_VALID |=> !RSP_VALID && REQ_READY)
    else $error("response pulse too long or host not ready");
  a_take_busy: assert property (take |=> !REQ_READY)
    else $error("host still ready after taking a request");
  a_read_latency: assert property (take && REQ.op == DFH_OP_READ |=> !RSP_VALID[*8] ##1 !RSP_VALID ##1 RSP_VALID)
    else $error("read answer not ten cycles after take");
  a_reset_pulse: assert property (take && REQ.op == DFH_OP_RESET |=>
    !FL_BUS.reset_n[*8] ##12 !FL_BUS.reset_n ##1 FL_BUS.reset_n ##2 RSP_VALID)
    else $error("reset pin pulse or recovery wrong");
  a_die_bit: assert property (!FL_BUS.ce_n |-> FL_BUS.addr[DIE_BIT] == adr_ff[DIE_BIT])
    else $error("bus cycle aimed at the wrong die");
  a_flat_read: assert property (!FL_BUS.ce_n && rd_ff |-> FL_BUS.addr == adr_ff)
    else $error("array read address altered");
  a_write_strobe: assert property (!FL_BUS.we_n |-> FL_BUS.oe_n && !FL_BUS.ce_n && FL_DQ_OE)
    else $error("write strobe without select or data drive");
  a_read_strobe: assert property (!FL_BUS.oe_n |-> !FL_DQ_OE && !FL_BUS.ce_n)
    else $error("host drives data during a read");
endmodule
